/* File: eee_pkg.sv */
// Purpose: Shared constants and types of the low power idle control block
// Assumes: 250 MHz device clock
// Notes:   Offsets are byte addresses on the plain register port
package eee_pkg;

  // Clock and derived tick rates
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int US_PS           = 1000000;
  localparam int US_TICK_CYC     = US_PS / CLK_PERIOD_PS;
  localparam int QUANTUM_GIG_NS  = 512;
  localparam int QUANTUM_FAST_NS = 5120;
  localparam int QUANTUM_GIG_CYC  = QUANTUM_GIG_NS * 1000 / CLK_PERIOD_PS;
  localparam int QUANTUM_FAST_CYC = QUANTUM_FAST_NS * 1000 / CLK_PERIOD_PS;
  localparam int LINKUP_HOLD_MS  = 1000;
  localparam int unsigned LINKUP_HOLD_CYC =
    32'(64'(LINKUP_HOLD_MS) * 64'd1000000000 / 64'(CLK_PERIOD_PS));

  // Link mode selecting the internal copper PHY
  localparam logic [1:0] LINK_MODE_INTERNAL = 2'h0;

  // Register map
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  OFF_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_LAT   = 8'h04;
  localparam logic [7:0]  OFF_STAT  = 8'h08;
  localparam logic [7:0]  OFF_TXCNT = 8'h0C;
  localparam logic [7:0]  OFF_RXCNT = 8'h10;

  // Control register fields
  localparam int CTRL_TX_EN    = 0;
  localparam int CTRL_RX_EN    = 1;
  localparam int CTRL_PAUSE_EN = 2;
  localparam int CTRL_FORCE    = 3;
  localparam int CTRL_ADV_GIG  = 4;
  localparam int CTRL_ADV_FAST = 5;
  localparam int CTRL_TW_LSB   = 16;
  localparam int TW_W          = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0030;

  // Latency register fields
  localparam int LAT_MIN_LSB = 0;
  localparam int LAT_MAX_LSB = 16;
  localparam int LAT_W       = 10;
  localparam int LAT_NEG_BIT = 31;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PAUSE     = 4;
  localparam int STAT_HOLD_DONE = 5;
  localparam int STAT_RX_LPI    = 6;
  localparam int STAT_TX_LPI    = 7;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_QUIET,
    ST_REFRESH,
    ST_WAKE
  } lpi_state_t;

endpackage

/* File: wake_timer.sv */
// Purpose: Microsecond timer counting time since transmit idle exit
// Assumes: start is a one-cycle pulse
// Notes:   Saturates at all ones
`timescale 1ns/1ps
module wake_timer #(
  parameter int TICK_CYC = 250,
  parameter int CNT_W    = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Control
  input  wire logic             start,
  // Elapsed microseconds
  output logic [CNT_W-1:0]      elapsed_r
);

  logic [15:0] div_r;
  logic        tick;

  assign tick = (div_r == 16'(TICK_CYC - 1));

  // One-cycle enable once per microsecond
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
    end else if (start || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_r <= '0;
    end else if (start) begin
      elapsed_r <= '0;
    end else if (tick && !(&elapsed_r)) begin
      elapsed_r <= elapsed_r + CNT_W'(1);
    end
  end

endmodule // wake_timer

/* File: event_counters.sv */
// Purpose: Saturating statistics counters, one per event input
// Assumes: Event inputs are one-cycle pulses
// Notes:   Counts are flattened, channel 0 in the low word
`timescale 1ns/1ps
module event_counters #(
  parameter int N = 2,
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  // Events and counts
  input  wire logic [N-1:0]   inc,
  output logic [N*W-1:0]      count_r
);

  for (genvar i = 0; i < N; i++) begin : g_cnt
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        count_r[i*W +: W] <= '0;
      end else if (inc[i] && !(&count_r[i*W +: W])) begin
        count_r[i*W +: W] <= count_r[i*W +: W] + W'(1);
      end
    end
  end

endmodule // event_counters

/* File: eee_lpi_ctrl.sv */
// Purpose: MAC-side transmit and receive low power idle control
// Assumes: All inputs except arst_n synchronous to clk_sys; xoff_rx is a one-cycle pulse
// Notes:   Registers on a plain port, read data one cycle after the strobe
`timescale 1ns/1ps
module eee_lpi_ctrl #(
  parameter int unsigned LINKUP_HOLD_CYC   = eee_pkg::LINKUP_HOLD_CYC,
  parameter int          SLEEP_CYC         = 64,
  parameter int          QUIET_CYC         = 4096,
  parameter int          REFRESH_CYC       = 64,
  parameter logic [15:0] MIN_WAKE_GIG_US   = 16'h0010,
  parameter logic [15:0] MIN_WAKE_FAST_US  = 16'h0020,
  parameter logic [15:0] PHY_WAKE_US       = 16'h0008
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_r,
  // Link status
  input  wire logic [1:0]  link_mode,
  input  wire logic        link_up,
  input  wire logic        an_restart,
  input  wire logic        link_gig,
  // Transmit side conditions
  input  wire logic        tx_pending,
  input  wire logic        mgmt_tx_pending,
  input  wire logic        tx_buf_empty,
  input  wire logic        host_frame_active,
  input  wire logic        d3_state,
  input  wire logic        xoff_rx,
  input  wire logic [15:0] pause_quanta,
  // PHY indications
  input  wire logic        rx_sleep_seen,
  input  wire logic        rx_lpi_ind,
  // Transmit interface toward PHY and MAC
  output logic             tx_lpi_assert,
  output logic             tx_quiet,
  output logic             tx_refresh,
  output logic             tx_wake_sym,
  output logic             tx_data_allow,
  output logic             tx_fc_allow,
  // Receive and negotiation outputs
  output logic             rx_lpi_active_r,
  output logic             adv_gig_idle,
  output logic             adv_fast_idle,
  output logic             wake_neg_enable_r,
  output logic [9:0]       min_latency_value,
  output logic [9:0]       max_latency_value
);

  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [31:0] ctrl_r;
  logic [9:0]  min_lat_r;
  logic [9:0]  max_lat_r;
  logic [31:0] hold_cnt_r;
  logic        hold_done;
  logic [15:0] pause_q_r;
  logic [10:0] pause_sub_r;
  logic        pause_active;
  logic        link_up_d_r;
  eee_pkg::lpi_state_t state_r;
  eee_pkg::lpi_state_t state_nxt;
  logic [15:0] phase_cnt_r;
  logic        phase_done;
  logic        gate;
  logic        enter_req;
  logic        wake_start;
  logic [15:0] elapsed;
  logic [15:0] min_us;
  logic        min_done;
  logic        sys_done;
  logic [63:0] counts;
  logic        rx_lpi_nxt;
  logic        tx_en;
  logic        force_idle;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= eee_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == eee_pkg::OFF_CTRL) begin
      ctrl_r <= reg_wdata;
    end
  end
  assign tx_en         = ctrl_r[eee_pkg::CTRL_TX_EN];
  assign force_idle    = ctrl_r[eee_pkg::CTRL_FORCE];
  assign adv_gig_idle  = ctrl_r[eee_pkg::CTRL_ADV_GIG];
  assign adv_fast_idle = ctrl_r[eee_pkg::CTRL_ADV_FAST];

  // Latency values and wake-negotiated bit; a software write beats the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      min_lat_r         <= 10'h000;
      max_lat_r         <= 10'h000;
      wake_neg_enable_r <= 1'b0;
    end else if (reg_wr && reg_addr == eee_pkg::OFF_LAT) begin
      min_lat_r         <= reg_wdata[eee_pkg::LAT_MIN_LSB +: eee_pkg::LAT_W];
      max_lat_r         <= reg_wdata[eee_pkg::LAT_MAX_LSB +: eee_pkg::LAT_W];
      wake_neg_enable_r <= reg_wdata[eee_pkg::LAT_NEG_BIT];
    end else if ((link_up_d_r && !link_up) || an_restart) begin
      wake_neg_enable_r <= 1'b0;
    end
  end
  assign min_latency_value = min_lat_r;
  assign max_latency_value = max_lat_r;

  // Hold-off after link-up or renegotiation
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_r  <= 32'h0000_0000;
      link_up_d_r <= 1'b0;
    end else begin
      link_up_d_r <= link_up;
      if (!link_up || an_restart) begin
        hold_cnt_r <= 32'h0000_0000;
      end else if (!hold_done) begin
        hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
      end
    end
  end
  assign hold_done = (hold_cnt_r == LINKUP_HOLD_CYC);

  // Pause duration from a received XOFF, in link-rate quanta
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pause_q_r   <= 16'h0000;
      pause_sub_r <= 11'h000;
    end else if (!link_up) begin
      pause_q_r   <= 16'h0000;
      pause_sub_r <= 11'h000;
    end else if (xoff_rx) begin
      pause_q_r   <= pause_quanta;
      pause_sub_r <= 11'h000;
    end else if (pause_active) begin
      if (pause_sub_r == (link_gig ? 11'(eee_pkg::QUANTUM_GIG_CYC - 1)
                                   : 11'(eee_pkg::QUANTUM_FAST_CYC - 1))) begin
        pause_sub_r <= 11'h000;
        pause_q_r   <= pause_q_r - 16'h0001;
      end else begin
        pause_sub_r <= pause_sub_r + 11'h001;
      end
    end
  end
  assign pause_active = (pause_q_r != 16'h0000);

  // Entry conditions
  assign gate = (link_mode == eee_pkg::LINK_MODE_INTERNAL)
                && link_up && hold_done;
  always_comb begin
    enter_req = 1'b0;
    if (gate && !host_frame_active) begin
      enter_req = (!tx_pending && !mgmt_tx_pending && tx_buf_empty && tx_en)
                || (tx_en && ctrl_r[eee_pkg::CTRL_PAUSE_EN] && pause_active)
                || (force_idle && !mgmt_tx_pending)
                || (d3_state && !mgmt_tx_pending && tx_buf_empty && tx_en);
    end
  end

  // Phase timer for sleep, quiet and refresh periods
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      phase_cnt_r <= 16'h0000;
    end else if (!phase_done) begin
      phase_cnt_r <= phase_cnt_r + 16'h0001;
    end
  end
  always_comb begin
    case (state_r)
      eee_pkg::ST_SLEEP:   phase_done = (phase_cnt_r >= 16'(SLEEP_CYC - 1));
      eee_pkg::ST_QUIET:   phase_done = (phase_cnt_r >= 16'(QUIET_CYC - 1));
      eee_pkg::ST_REFRESH: phase_done = (phase_cnt_r >= 16'(REFRESH_CYC - 1));
      default:             phase_done = 1'b0;
    endcase
  end

  // Transmit idle state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      eee_pkg::ST_ACTIVE: begin
        if (enter_req) begin
          state_nxt = eee_pkg::ST_SLEEP;
        end
      end
      eee_pkg::ST_SLEEP: begin
        if (!enter_req) begin
          state_nxt = eee_pkg::ST_WAKE;
        end else if (phase_done && (!link_gig || rx_sleep_seen)) begin
          state_nxt = eee_pkg::ST_QUIET;
        end
      end
      eee_pkg::ST_QUIET: begin
        if (!enter_req) begin
          state_nxt = eee_pkg::ST_WAKE;
        end else if (phase_done) begin
          state_nxt = eee_pkg::ST_REFRESH;
        end
      end
      eee_pkg::ST_REFRESH: begin
        if (!enter_req) begin
          state_nxt = eee_pkg::ST_WAKE;
        end else if (phase_done) begin
          state_nxt = eee_pkg::ST_QUIET;
        end
      end
      eee_pkg::ST_WAKE: begin
        if (sys_done) begin
          state_nxt = eee_pkg::ST_ACTIVE;
        end
      end
      default: state_nxt = eee_pkg::ST_ACTIVE;
    endcase
    if (!gate && state_r != eee_pkg::ST_ACTIVE) begin
      state_nxt = link_up ? eee_pkg::ST_WAKE : eee_pkg::ST_ACTIVE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= eee_pkg::ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Wake timing, restarted at every entry to the wake state
  assign wake_start = (state_nxt == eee_pkg::ST_WAKE) && (state_r != eee_pkg::ST_WAKE);

  wake_timer #(
    .TICK_CYC (eee_pkg::US_TICK_CYC),
    .CNT_W    (16)
  ) u_wake_timer (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .start     (wake_start),
    .elapsed_r (elapsed)
  );

  assign min_us   = link_gig ? MIN_WAKE_GIG_US : MIN_WAKE_FAST_US;
  assign min_done = (elapsed >= min_us);
  assign sys_done = min_done
                    && (elapsed >= ctrl_r[eee_pkg::CTRL_TW_LSB +: eee_pkg::TW_W]);

  // Transmit interface outputs decoded from the state register, wake timer and force bit
  assign tx_lpi_assert = (state_r == eee_pkg::ST_SLEEP) || (state_r == eee_pkg::ST_QUIET)
                         || (state_r == eee_pkg::ST_REFRESH);
  assign tx_quiet      = (state_r == eee_pkg::ST_QUIET);
  assign tx_refresh    = (state_r == eee_pkg::ST_REFRESH);
  assign tx_wake_sym   = (state_r == eee_pkg::ST_WAKE) && (elapsed < PHY_WAKE_US);
  assign tx_data_allow = (state_r == eee_pkg::ST_ACTIVE) && !force_idle;
  assign tx_fc_allow   = (state_r == eee_pkg::ST_ACTIVE)
                         || ((state_r == eee_pkg::ST_WAKE) && min_done);

  // Receive idle follows the PHY indication when enabled, with link up in internal mode
  assign rx_lpi_nxt = ctrl_r[eee_pkg::CTRL_RX_EN] && rx_lpi_ind && link_up
                      && (link_mode == eee_pkg::LINK_MODE_INTERNAL);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_lpi_active_r <= 1'b0;
    end else begin
      rx_lpi_active_r <= rx_lpi_nxt;
    end
  end

  // Idle event statistics
  event_counters #(
    .N (2),
    .W (32)
  ) u_stats (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .inc     ({rx_lpi_nxt && !rx_lpi_active_r,
               (state_r == eee_pkg::ST_ACTIVE) && (state_nxt == eee_pkg::ST_SLEEP)}),
    .count_r (counts)
  );

  // Register read, data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        eee_pkg::OFF_CTRL: reg_rdata_r <= ctrl_r;
        eee_pkg::OFF_LAT: begin
          reg_rdata_r                                         <= 32'h0000_0000;
          reg_rdata_r[eee_pkg::LAT_MIN_LSB +: eee_pkg::LAT_W] <= min_lat_r;
          reg_rdata_r[eee_pkg::LAT_MAX_LSB +: eee_pkg::LAT_W] <= max_lat_r;
          reg_rdata_r[eee_pkg::LAT_NEG_BIT]                   <= wake_neg_enable_r;
        end
        eee_pkg::OFF_STAT: begin
          reg_rdata_r                                 <= 32'h0000_0000;
          reg_rdata_r[eee_pkg::STAT_STATE_LSB +: 3]   <= 3'(state_r);
          reg_rdata_r[eee_pkg::STAT_PAUSE]            <= pause_active;
          reg_rdata_r[eee_pkg::STAT_HOLD_DONE]        <= hold_done;
          reg_rdata_r[eee_pkg::STAT_RX_LPI]           <= rx_lpi_active_r;
          reg_rdata_r[eee_pkg::STAT_TX_LPI]           <= tx_lpi_assert;
        end
        eee_pkg::OFF_TXCNT: reg_rdata_r <= counts[31:0];
        eee_pkg::OFF_RXCNT: reg_rdata_r <= counts[63:32];
        default:            reg_rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

  // Checks
  property p_mode_gate;
    @(posedge clk_sys) disable iff (!rst_n)
      (link_mode != eee_pkg::LINK_MODE_INTERNAL) |=> !tx_lpi_assert;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("idle outside internal mode");

  property p_enter;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == eee_pkg::ST_ACTIVE && enter_req) |=> tx_lpi_assert;
  endproperty
  a_enter: assert property (p_enter) else $error("entry condition not followed");

  property p_frame_done;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == eee_pkg::ST_ACTIVE && host_frame_active) |=> !tx_lpi_assert;
  endproperty
  a_frame_done: assert property (p_frame_done) else $error("idle entered mid frame");

  property p_exit;
    @(posedge clk_sys) disable iff (!rst_n)
      (tx_lpi_assert && !enter_req && link_up) |=> (state_r == eee_pkg::ST_WAKE);
  endproperty
  a_exit: assert property (p_exit) else $error("idle not left");

  property p_fast_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == eee_pkg::ST_SLEEP && phase_done && !link_gig && enter_req)
        |=> (state_r == eee_pkg::ST_QUIET);
  endproperty
  a_fast_quiet: assert property (p_fast_quiet) else $error("fast quiet late");

  property p_gig_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == eee_pkg::ST_SLEEP && link_gig && !rx_sleep_seen) |=> !tx_quiet;
  endproperty
  a_gig_wait: assert property (p_gig_wait) else $error("gig quiet too early");

  property p_data_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == eee_pkg::ST_WAKE) |-> !tx_data_allow;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data during wake");

  property p_fc_early;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == eee_pkg::ST_WAKE && elapsed >= min_us) |-> tx_fc_allow;
  endproperty
  a_fc_early: assert property (p_fc_early) else $error("pause frame held");

  property p_link_down;
    @(posedge clk_sys) disable iff (!rst_n)
      !link_up |=> (state_r == eee_pkg::ST_ACTIVE) && !tx_lpi_assert;
  endproperty
  a_link_down: assert property (p_link_down) else $error("idle while link down");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(link_up) |-> !enter_req [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("idle before hold-off");

  property p_neg_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (an_restart && !reg_wr) |=> !wake_neg_enable_r;
  endproperty
  a_neg_clear: assert property (p_neg_clear) else $error("negotiated bit kept");

  property p_wake_restart;
    @(posedge clk_sys) disable iff (!rst_n)
      wake_start |=> (elapsed == 16'h0000);
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("wake timer not cleared");

  c_quiet:   cover property (@(posedge clk_sys) disable iff (!rst_n) tx_quiet);
  c_refresh: cover property (@(posedge clk_sys) disable iff (!rst_n) tx_refresh);
  c_wake:    cover property (@(posedge clk_sys) disable iff (!rst_n)
                             state_r == eee_pkg::ST_WAKE ##1 state_r == eee_pkg::ST_ACTIVE);
  c_rx_lpi:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(rx_lpi_active_r));

endmodule // eee_lpi_ctrl

/* File: phy_model.sv */
// Purpose: Behavioural copper PHY facing the idle control block
// Assumes: Partner sleep is commanded by the bench
// Notes:   Gigabit partner answers sleep only while told to sleep
`timescale 1ns/1ps
module phy_model (
  // Clock
  input  wire logic clk_sys,
  // From MAC and bench
  input  wire logic tx_lpi_assert,
  input  wire logic link_gig,
  input  wire logic partner_sleep,
  // To MAC
  output logic      rx_sleep_seen,
  output logic      rx_lpi_ind
);
  initial rx_sleep_seen = 1'b0;
  initial rx_lpi_ind = 1'b0;
  always @(posedge clk_sys) begin
    rx_sleep_seen <= tx_lpi_assert & link_gig & partner_sleep;
    rx_lpi_ind <= partner_sleep;
  end
endmodule // phy_model

/* File: eee_lpi_ctrl_tb.sv */
// Purpose: Self-checking bench of the low power idle control block
// Assumes: Short hold-off and idle counts set by parameter
// Notes:   Fast link except in the D3 test; wake times in microseconds of 250 cycles
`timescale 1ns/1ps
module eee_lpi_ctrl_tb;
  logic clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, link_up = 0, link_gig = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_r;
  logic [1:0] link_mode = 2'h1;
  logic tx_pending = 0, mgmt = 0, psleep = 0, sleep_seen, lpi_ind;
  logic anr = 0, hfa = 0, d3 = 0, xoff = 0, bufe = 1;
  logic [15:0] pq = 16'h0000;
  logic lpi, quiet, refr, wsym, dal, fal, rxa, neg, advg, advf;
  logic [9:0] minl, maxl;
  int bad_count = 0, cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  eee_lpi_ctrl #(.LINKUP_HOLD_CYC(20), .SLEEP_CYC(8), .QUIET_CYC(16), .REFRESH_CYC(8),
    .MIN_WAKE_FAST_US(16'h0002), .PHY_WAKE_US(16'h0001)) u_eee_lpi_ctrl (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .link_mode(link_mode),
    .link_up(link_up), .an_restart(anr), .link_gig(link_gig), .tx_pending(tx_pending),
    .mgmt_tx_pending(mgmt), .tx_buf_empty(bufe), .host_frame_active(hfa),
    .d3_state(d3), .xoff_rx(xoff), .pause_quanta(pq),
    .rx_sleep_seen(sleep_seen), .rx_lpi_ind(lpi_ind), .tx_lpi_assert(lpi),
    .tx_quiet(quiet), .tx_refresh(refr), .tx_wake_sym(wsym), .tx_data_allow(dal),
    .tx_fc_allow(fal), .rx_lpi_active_r(rxa), .adv_gig_idle(advg), .adv_fast_idle(advf),
    .wake_neg_enable_r(neg), .min_latency_value(minl), .max_latency_value(maxl));
  phy_model u_phy_model (.clk_sys(clk_sys), .tx_lpi_assert(lpi), .link_gig(link_gig),
    .partner_sleep(psleep), .rx_sleep_seen(sleep_seen), .rx_lpi_ind(lpi_ind));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd(string what, logic [7:0] a, logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    @(negedge clk_sys);
    chk(what, reg_rdata_r, exp);
  endtask
  task automatic at(int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic t_regs;
    rd("ctrl", eee_pkg::OFF_CTRL, eee_pkg::CTRL_RST);
    chk("adv fast rst", advf, 1'b1);
    rd("unmapped", 8'h20, 32'h0000_0000);
    wr(eee_pkg::OFF_CTRL, 32'h0004_0013);
    at(1);
    chk("adv gig", advg, 1'b1);
    chk("adv fast", advf, 1'b0);
  endtask
  task automatic t_enter;
    @(posedge clk_sys);
    link_up <= 1;
    at(40);
    chk("mode gate", lpi, 1'b0);
    @(posedge clk_sys);
    link_mode <= 2'h0;
    at(4);
    chk("lpi", lpi, 1'b1);
    chk("data", dal, 1'b0);
    at(10);
    chk("quiet", quiet, 1'b1);
    rd("status", eee_pkg::OFF_STAT, 32'h0000_00A2);
    at(10);
    chk("refresh", refr, 1'b1);
  endtask
  task automatic t_exit;
    @(posedge clk_sys);
    tx_pending <= 1;
    at(3);
    chk("lpi off", lpi, 1'b0);
    chk("wake sym", wsym, 1'b1);
    at(370);
    chk("wake sym end", wsym, 1'b0);
    chk("fc early", fal, 1'b0);
    at(250);
    chk("fc", fal, 1'b1);
    chk("data held", dal, 1'b0);
    at(600);
    chk("data", dal, 1'b1);
    rd("tx count", eee_pkg::OFF_TXCNT, 32'h0000_0001);
  endtask
  task automatic t_force;
    @(posedge clk_sys);
    hfa <= 1;
    wr(eee_pkg::OFF_CTRL, 32'h0004_001B);
    at(4);
    chk("frame first", lpi, 1'b0);
    chk("force data", dal, 1'b0);
    @(posedge clk_sys);
    hfa <= 0;
    at(3);
    chk("force lpi", lpi, 1'b1);
    @(posedge clk_sys);
    mgmt <= 1;
    at(3);
    chk("mgmt wake", lpi, 1'b0);
    @(posedge clk_sys);
    mgmt <= 0;
    wr(eee_pkg::OFF_CTRL, 32'h0000_0013);
    at(600);
    chk("force off", dal, 1'b1);
  endtask
  task automatic t_pause;
    wr(eee_pkg::OFF_CTRL, 32'h0000_0017);
    @(posedge clk_sys);
    xoff <= 1;
    pq <= 16'h0002;
    @(posedge clk_sys);
    xoff <= 0;
    at(3);
    chk("pause lpi", lpi, 1'b1);
    @(posedge clk_sys);
    xoff <= 1;
    pq <= 16'h0000;
    @(posedge clk_sys);
    xoff <= 0;
    at(3);
    chk("pause end", lpi, 1'b0);
    at(600);
    chk("pause data", dal, 1'b1);
  endtask
  task automatic t_d3;
    @(posedge clk_sys);
    link_gig <= 1;
    d3 <= 1;
    at(20);
    chk("d3 lpi", lpi, 1'b1);
    chk("gig wait", quiet, 1'b0);
    @(posedge clk_sys);
    psleep <= 1;
    at(4);
    chk("gig quiet", quiet, 1'b1);
    @(posedge clk_sys);
    bufe <= 0;
    at(3);
    chk("d3 busy", lpi, 1'b0);
    @(posedge clk_sys);
    bufe <= 1;
    d3 <= 0;
    link_gig <= 0;
  endtask
  task automatic t_rx;
    @(posedge clk_sys);
    psleep <= 1;
    at(4);
    chk("rx idle", rxa, 1'b1);
    rd("rx count", eee_pkg::OFF_RXCNT, 32'h0000_0001);
    wr(eee_pkg::OFF_LAT, 32'h8018_0010);
    at(1);
    chk("neg set", neg, 1'b1);
    chk("min lat", minl, 10'h010);
    chk("max lat", maxl, 10'h018);
    @(posedge clk_sys);
    anr <= 1;
    @(posedge clk_sys);
    anr <= 0;
    at(1);
    chk("neg restart", neg, 1'b0);
    rd("status hold", eee_pkg::OFF_STAT, 32'h0000_0044);
    wr(eee_pkg::OFF_LAT, 32'h8018_0010);
    at(1);
    chk("neg set again", neg, 1'b1);
    @(posedge clk_sys);
    link_up <= 0;
    at(3);
    chk("neg clear", neg, 1'b0);
    chk("down", lpi, 1'b0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1;
    at(4);
    t_regs();
    t_enter();
    t_exit();
    t_force();
    t_pause();
    t_d3();
    t_rx();
    test_done();
  end
  initial begin
    #40000;
    bad_count++;
    test_done();
  end
endmodule // eee_lpi_ctrl_tb
